// *** nic_decoder.sv ***
// Purpose: decodes indexed command words and steers data-window accesses
// Assumes: single 40 MHz clock, synchronous active-low reset
// Notes: flash sequencer and page buffer sit behind the op and data ports
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Function
// R1: buffer command: class 0, word buffer address in 12:2, rest zero, one page.
// R2: buffer accesses address from zero up to main plus spare size.
// R3: host issues buffer accesses only when no transfer or control op runs.
// R4: buffer path moves data without any error correction.
// R5: host keeps data DMA disabled during buffer operations.
// R6: host never mixes buffer accesses into a page transfer.
// R7: transfer command: class 1, zero reserved bits, block above page index.
// R8: block/page split point is the configured page-bit count.
// R9: transfer read loads the page first, then returns words in order.
// R10: transfer writes come in order; program is issued after the last word.
// R11: byte enables ignored on transfers; whole word always moves.
// R12: device counts moved words; host keeps the same command word.
// R13: host rewrites the command word only after a full page.
// R14: transfer command with DMA enabled is dropped and flagged unsupported.
// R15: control command: class 2, zero reserved bits, same block/page split.
// R16: control data uses low 16 bits as opcode, never touches flash data.
// R17: 0x01 latches erase block and starts erase.
// R18: 0x10 latches unlock start; 0x11 latches end and starts unlock.
// R19: 0x21 locks all blocks; 0x31 lock-tights all blocks.
// R20: 0x41, 0x42, 0x43 select spare, default, main plus spare area.
// R21: 0x60 loads page, 0x61 sets destination, 0x62 writes buffer back.
// R22: 0x1000 latches copy source; 0x11 with count copies that many pages.
// R23: 0x20 or 0x21 with count sets up pipelined read or write.
// R24: command word at offset 0x0, data window from 0x10, word aligned.
// R25: latched command class steers data accesses to buffer, transfer or control.
module nic_decoder
  import nic_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter logic [3:0] PAGE_BITS = PBITS_RST,
  parameter logic [15:0] MAIN_BYTES = MAIN_BYTES_RST,
  parameter logic [15:0] SPARE_BYTES = SPARE_BYTES_RST
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output nic_op_req_t o_op,
  output logic o_op_start,
  input wire logic i_op_done,
  output logic o_dat_req,
  output logic o_dat_we,
  output logic [15:0] o_dat_addr,
  output logic [31:0] o_dat_wdata,
  input wire logic i_dat_ack,
  input wire logic [31:0] i_dat_rdata,
  output logic [1:0] o_area,
  output logic o_unsup_cmd
);
  logic [31:0] cmd;
  logic cmd_valid;
  logic [31:0] cfg;
  logic [31:0] geom;
  nic_state_t state;
  logic loaded;
  logic [15:0] count;
  logic [23:0] unlock_lo;
  logic [23:0] copy_src;

  // command word fields and reserved-bit checks
  wire [1:0] cls = cmd[27:26];
  wire [1:0] wcls = i_writedata[27:26];
  wire res_hi_ok = i_writedata[31:28] == 4'h0;
  wire buf_fmt_ok = (i_writedata[25:13] == 13'h0000) && (i_writedata[1:0] == 2'h0);
  wire row_fmt_ok = i_writedata[25:24] == 2'h0;
  wire dma_en = cfg[CFG_DMA_BIT];
  wire [3:0] pbits = cfg[CFG_PBITS_LSB +: 4];
  wire [23:0] page_mask = (24'h00_0001 << pbits) - 24'h00_0001;
  wire [23:0] row = cmd[23:0];
  wire [23:0] blk_row = row & ~page_mask;

  // page geometry in words
  wire [15:0] main_w = {2'h0, geom[15:2]};
  wire [15:0] spare_w = {2'h0, geom[31:18]};
  wire [15:0] page_w = main_w + spare_w;
  wire [15:0] xfer_w = (o_area == AREA_SPARE) ? spare_w :
                       (o_area == AREA_BOTH) ? page_w : main_w;
  wire [15:0] nxt_count = count + 16'h0001;
  wire last_word = nxt_count == xfer_w;

  // bus address decode
  wire req = i_read | i_write;
  wire is_cmd = i_address == CMD_OFF[ADDR_W-1:0];
  wire is_cfg = i_address == CFG_OFF[ADDR_W-1:0];
  wire is_geom = i_address == GEOM_OFF[ADDR_W-1:0];
  wire is_stat = i_address == STAT_OFF[ADDR_W-1:0];
  wire is_win = i_address >= DATA_OFF[ADDR_W-1:0];
  wire [ADDR_W-1:0] win_off = i_address - DATA_OFF[ADDR_W-1:0];
  wire [15:0] win_word = 16'(win_off >> 2);
  wire [15:0] buf_addr = {5'h00, cmd[12:2]} + win_word;
  wire buf_ok = buf_addr < page_w;
  wire [31:0] stat_word = {24'h00_0000, 1'b0, o_area, loaded, cmd_valid, dma_en, cls};

  // a command word is kept only when its format is legal and DMA allows it
  wire wcmd_fmt = res_hi_ok && ((wcls == CLS_BUF) ? buf_fmt_ok :
                  (wcls == CLS_XFER || wcls == CLS_CTRL) ? row_fmt_ok : 1'b0);
  wire wcmd_drop = dma_en && (wcls != CLS_CTRL);

  // control opcode decode
  wire [15:0] opc = i_writedata[15:0];
  wire [7:0] opc_pp = opc[7:0];
  wire [24:0] pipe_end = {1'b0, row & page_mask} + {17'h0_0000, opc_pp};
  wire pipe_cross = pipe_end > ({1'b0, page_mask} + 25'h000_0001);
  nic_op_req_t dec_op;
  logic dec_start;
  logic dec_unl;
  logic dec_cpy;
  logic dec_area;
  logic dec_bad;

  // only the low half of the data word matters; it never reaches the flash array
  always_comb begin
    dec_op = '{code: OP_NONE, row: row, row2: 24'h00_0000, count: 8'h00};
    dec_start = 1'b0;
    dec_unl = 1'b0;
    dec_cpy = 1'b0;
    dec_area = 1'b0;
    dec_bad = 1'b0;
    if (opc == OPC_ERASE) begin // see R17
      dec_op.code = OP_ERASE;
      dec_op.row = blk_row; // see R8
      dec_start = 1'b1;
    end else if (opc == OPC_UNL_LO) begin // see R18
      dec_unl = 1'b1;
    end else if (opc == OPC_UNL_HI) begin // see R18
      dec_op.code = OP_UNLOCK;
      dec_op.row2 = unlock_lo;
      dec_start = 1'b1;
    end else if (opc == OPC_LOCK || opc == OPC_LOCKT) begin // see R19
      dec_op.code = (opc == OPC_LOCK) ? OP_LOCK : OP_LOCK_TIGHT;
      dec_start = 1'b1;
    end else if (opc == OPC_AR_SP || opc == OPC_AR_DEF || opc == OPC_AR_BOTH) begin
      dec_area = 1'b1; // see R20
    end else if (opc == OPC_RMW_LD || opc == OPC_RMW_DST || opc == OPC_RMW_WR) begin
      dec_op.code = (opc == OPC_RMW_LD) ? OP_RMW_LOAD : // see R21
                    (opc == OPC_RMW_DST) ? OP_RMW_DEST : OP_RMW_WRITE;
      dec_start = 1'b1;
    end else if (opc == OPC_CPY_SRC) begin // see R22
      dec_cpy = 1'b1;
    end else if (opc[15:8] == OPH_COPY) begin // see R22
      dec_op.code = OP_COPY;
      dec_op.row2 = copy_src;
      dec_op.count = opc_pp;
      dec_start = 1'b1;
    end else if (opc[15:8] == OPH_PIPE_RD || opc[15:8] == OPH_PIPE_WR) begin
      // pipelines may not run past the block end; such requests are refused
      dec_op.code = (opc[15:8] == OPH_PIPE_RD) ? OP_PIPE_RD : OP_PIPE_WR; // see R23
      dec_op.count = opc_pp;
      dec_start = !pipe_cross; // see R8
      dec_bad = pipe_cross;
    end else begin
      dec_bad = 1'b1;
    end
  end

  // register file, command latch and access sequencer in one machine
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cmd <= 32'h0000_0000;
      cmd_valid <= 1'b0;
      cfg <= {24'h00_0000, PAGE_BITS, 4'h0};
      geom <= {SPARE_BYTES, MAIN_BYTES};
      state <= ST_IDLE;
      loaded <= 1'b0;
      count <= 16'h0000;
      unlock_lo <= 24'h00_0000;
      copy_src <= 24'h00_0000;
      o_readdata <= 32'h0000_0000;
      o_waitrequest <= 1'b1;
      o_op <= '{code: OP_NONE, row: 24'h00_0000, row2: 24'h00_0000, count: 8'h00};
      o_op_start <= 1'b0;
      o_dat_req <= 1'b0;
      o_dat_we <= 1'b0;
      o_dat_addr <= 16'h0000;
      o_dat_wdata <= 32'h0000_0000;
      o_area <= AREA_DEFAULT;
      o_unsup_cmd <= 1'b0;
    end else begin
      o_op_start <= 1'b0;
      o_unsup_cmd <= 1'b0;
      o_waitrequest <= 1'b1;
      unique case (state)
        ST_IDLE: begin
          if (req && !is_win) begin
            // register accesses answer on the next edge
            state <= ST_RESP;
            o_waitrequest <= 1'b0;
            o_readdata <= 32'h0000_0000;
            if (i_write && is_cmd) begin // see R24
              cmd <= i_writedata;
              cmd_valid <= wcmd_fmt && !wcmd_drop; // see R1 R7 R15
              o_unsup_cmd <= !wcmd_fmt || wcmd_drop; // see R14
              loaded <= 1'b0; // see R13
              count <= 16'h0000;
            end
            if (i_write && is_cfg) cfg <= i_writedata;
            if (i_write && is_geom) geom <= i_writedata;
            if (i_read && is_cfg) o_readdata <= cfg;
            if (i_read && is_geom) o_readdata <= geom;
            if (i_read && is_stat) o_readdata <= stat_word;
          end else if (req && !cmd_valid) begin
            // window access with no usable command: answer zero, flag it
            state <= ST_RESP;
            o_waitrequest <= 1'b0;
            o_readdata <= 32'h0000_0000;
            o_unsup_cmd <= 1'b1;
          end else if (req && cls == CLS_BUF) begin // see R25
            // out-of-page accesses read zero and drop writes; no correction
            o_readdata <= 32'h0000_0000;
            if (buf_ok) begin // see R2 R3
              state <= ST_DATA;
              o_dat_req <= 1'b1;
              o_dat_we <= i_write;
              o_dat_addr <= buf_addr; // see R1
              o_dat_wdata <= i_writedata; // see R4
            end else begin
              state <= ST_RESP;
              o_waitrequest <= 1'b0;
            end
          end else if (req && cls == CLS_XFER) begin // see R25
            if (i_read && !loaded) begin
              // the page has to be in the device buffer before any word returns
              state <= ST_OP; // see R9
              o_op_start <= 1'b1;
              o_op <= '{code: OP_PAGE_LOAD, row: row, row2: 24'h00_0000, count: 8'h01};
            end else begin
              // window offset and byte enables are ignored: the count orders data
              state <= ST_DATA; // see R11 R12
              o_dat_req <= 1'b1;
              o_dat_we <= i_write;
              o_dat_addr <= count;
              o_dat_wdata <= i_writedata;
            end
          end else if (req) begin // see R25
            state <= ST_RESP;
            o_waitrequest <= 1'b0;
            o_readdata <= i_read ? stat_word : 32'h0000_0000;
            if (i_write) begin // see R16
              if (dec_unl) unlock_lo <= row;
              if (dec_cpy) copy_src <= row;
              if (dec_area) o_area <= opc[1:0];
              o_unsup_cmd <= dec_bad;
              if (dec_start) begin
                // the answer waits until the sequencer reports the op done
                state <= ST_OP;
                o_waitrequest <= 1'b1;
                o_op_start <= 1'b1;
                o_op <= dec_op;
              end
            end
          end
        end
        ST_DATA: begin
          if (i_dat_ack) begin
            o_dat_req <= 1'b0;
            o_readdata <= o_dat_we ? 32'h0000_0000 : i_dat_rdata;
            state <= ST_RESP;
            o_waitrequest <= 1'b0;
            if (cls == CLS_XFER) begin
              count <= last_word ? 16'h0000 : nxt_count; // see R12
              if (last_word && !o_dat_we) loaded <= 1'b0;
              if (last_word && o_dat_we) begin
                // program only after the last word of the selected area has been written
                state <= ST_OP; // see R10
                o_waitrequest <= 1'b1;
                o_op_start <= 1'b1;
                o_op <= '{code: OP_PAGE_PROG, row: row, row2: 24'h00_0000, count: 8'h01};
              end
            end
          end
        end
        ST_OP: begin
          // a finished page load returns to idle so the held read is retaken
          if (i_op_done) begin
            if (o_op.code == OP_PAGE_LOAD) begin
              loaded <= 1'b1;
              state <= ST_IDLE;
            end else begin
              state <= ST_RESP;
              o_waitrequest <= 1'b0;
            end
          end
        end
        ST_RESP: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // checks on the decoder's own behaviour
  default clocking dcb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  cmd_latch_a: assert property ( // see R24
    (state == ST_IDLE && i_write && is_cmd) |=> (cmd == $past(i_writedata)) && !o_waitrequest)
    else $error("command word not latched");

  dma_drop_a: assert property ( // see R14
    (state == ST_IDLE && i_write && is_cmd && dma_en && wcls == CLS_XFER)
      |=> o_unsup_cmd && !cmd_valid)
    else $error("transfer command kept while dma enabled");

  load_first_a: assert property ( // see R9
    (o_dat_req && !o_dat_we && cls == CLS_XFER) |-> loaded)
    else $error("transfer read data before page load");

  erase_row_a: assert property ( // see R17
    (o_op_start && o_op.code == OP_ERASE) |-> ((o_op.row & page_mask) == 24'h00_0000))
    else $error("erase row carries page bits");

  prog_after_a: assert property ( // see R10
    (state == ST_DATA && i_dat_ack && o_dat_we && cls == CLS_XFER && last_word)
      |=> o_op_start && o_op.code == OP_PAGE_PROG ##1 !o_op_start)
    else $error("program not issued after last word");

  ctrl_no_data_a: assert property ( // see R16
    (cls == CLS_CTRL && state != ST_DATA) |=> !o_dat_req)
    else $error("control command reached data path");

  area_sel_a: assert property ( // see R20
    (state == ST_IDLE && i_write && is_win && cmd_valid && cls == CLS_CTRL && dec_area)
      |=> o_area == $past(opc[1:0]))
    else $error("area selection not taken");

  buf_range_a: assert property ( // see R2
    (o_dat_req && cls == CLS_BUF) |-> (o_dat_addr < page_w))
    else $error("buffer access past page end");

  wait_pulse_a: assert property ( // see R24
    !o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");

  xfer_word_a: assert property ( // see R11
    (state == ST_IDLE && i_write && is_win && cmd_valid && cls == CLS_XFER)
      |=> o_dat_req && o_dat_we && o_dat_wdata == $past(i_writedata))
    else $error("transfer word not moved whole");

  win_refuse_a: assert property ( // see R25
    (state == ST_IDLE && req && is_win && !cmd_valid)
      |=> o_unsup_cmd && !o_waitrequest && o_readdata == 32'h0000_0000)
    else $error("window access without command not refused");

  buf_past_a: assert property ( // see R2
    (state == ST_IDLE && req && is_win && cmd_valid && cls == CLS_BUF && !buf_ok)
      |=> !o_waitrequest && !o_dat_req && o_readdata == 32'h0000_0000)
    else $error("buffer access past page not refused");

  pipe_cross_a: assert property ( // see R23
    (state == ST_IDLE && i_write && is_win && cmd_valid && cls == CLS_CTRL && pipe_cross
      && (opc[15:8] == OPH_PIPE_RD || opc[15:8] == OPH_PIPE_WR)) |=> o_unsup_cmd && !o_op_start)
    else $error("pipeline across block end not dropped");

  load_req_a: assert property ( // see R9
    (state == ST_IDLE && i_read && is_win && cmd_valid && cls == CLS_XFER && !loaded)
      |=> o_op_start && o_op.code == OP_PAGE_LOAD && o_waitrequest && !o_dat_req)
    else $error("transfer read did not load the page first");

  op_wait_a: assert property ( // see R17
    (state == ST_OP && !i_op_done)
      |=> o_waitrequest && !o_op_start)
    else $error("answer given before the op finished");

  copy_src_a: assert property ( // see R22
    (o_op_start && o_op.code == OP_COPY)
      |-> o_op.row2 == copy_src)
    else $error("copy source not carried");
endmodule

// *** nic_flash_model.sv ***
// Purpose: flash sequencer and device page buffer seen from the decoder
// Assumes: at most one op and one data request outstanding
// Notes: stores one programmed page; any other row loads as inverted junk
`timescale 1ns/1ps
module nic_flash_model
  import nic_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_slow,
  input wire nic_op_req_t i_op,
  input wire logic i_op_start,
  output logic o_op_done,
  input wire logic i_dat_req,
  input wire logic i_dat_we,
  input wire logic [15:0] i_dat_addr,
  input wire logic [31:0] i_dat_wdata,
  output logic o_dat_ack,
  output logic [31:0] o_dat_rdata
);
  logic [31:0] buff [0:1023];
  logic [31:0] page [0:1023];
  logic [23:0] page_row;
  int op_cnt;
  int dat_cnt;
  initial begin
    o_op_done = 1'b0;
    o_dat_ack = 1'b0;
    o_dat_rdata = 32'h0000_0000;
    op_cnt = 0;
    dat_cnt = 0;
    page_row = 24'h00_0000;
    for (int k = 0; k < 1024; k++) begin
      buff[k] = 32'h5A00_0000 + k;
      page[k] = buff[k];
    end
  end
  // ops act at start; done comes after a short or long wait
  always @(posedge i_clock) begin
    o_op_done <= 1'b0;
    if (op_cnt == 1) begin
      o_op_done <= 1'b1;
    end
    if (op_cnt > 0) begin
      op_cnt--;
    end
    if (i_op_start === 1'b1) begin
      op_cnt = i_slow ? 9 : 2;
      if (i_op.code == OP_PAGE_PROG) begin
        page_row = i_op.row;
        for (int k = 0; k < 1024; k++) begin
          page[k] = buff[k];
          buff[k] = ~buff[k]; // a skipped load then reads garbage
        end
      end else if (i_op.code == OP_PAGE_LOAD) begin
        for (int k = 0; k < 1024; k++) begin
          buff[k] = (i_op.row == page_row) ? page[k] : ~page[k];
        end
      end
      // other ops leave buffer and page alone
    end
  end
  // data side: raw words, no correction applied
  always @(posedge i_clock) begin
    o_dat_ack <= 1'b0;
    o_dat_rdata <= ~o_dat_rdata; // released bus never holds old data
    if (i_dat_req === 1'b1 && o_dat_ack !== 1'b1) begin
      if (dat_cnt >= (i_slow ? 4 : 0)) begin
        dat_cnt = 0;
        o_dat_ack <= 1'b1;
        o_dat_rdata <= buff[i_dat_addr[9:0]];
        if (i_dat_we === 1'b1) begin
          buff[i_dat_addr[9:0]] = i_dat_wdata;
        end
      end else begin
        dat_cnt++;
      end
    end
  end
endmodule

// *** nic_pkg.sv ***
// Purpose: shared constants and types of the indexed command decoder
// Assumes: 32-bit Avalon-MM register window, byte addresses
// Notes: operation codes are the low 16 bits of a control-class data write
package nic_pkg;
  // register window, byte offsets
  localparam logic [31:0] CMD_OFF = 32'h0000_0000;
  localparam logic [31:0] CFG_OFF = 32'h0000_0004;
  localparam logic [31:0] GEOM_OFF = 32'h0000_0008;
  localparam logic [31:0] STAT_OFF = 32'h0000_000C;
  localparam logic [31:0] DATA_OFF = 32'h0000_0010;
  // command word classes, bits 27:26
  localparam logic [1:0] CLS_BUF = 2'h0;
  localparam logic [1:0] CLS_XFER = 2'h1;
  localparam logic [1:0] CLS_CTRL = 2'h2;
  // config register fields
  localparam int CFG_DMA_BIT = 0;
  localparam int CFG_PBITS_LSB = 4;
  localparam logic [3:0] PBITS_RST = 4'h6;
  localparam logic [15:0] MAIN_BYTES_RST = 16'h0800;
  localparam logic [15:0] SPARE_BYTES_RST = 16'h0040;
  // area selection, equal to the low bits of opcodes 0x41..0x43
  localparam logic [1:0] AREA_SPARE = 2'h1;
  localparam logic [1:0] AREA_DEFAULT = 2'h2;
  localparam logic [1:0] AREA_BOTH = 2'h3;
  // control-class operation codes
  localparam logic [15:0] OPC_ERASE = 16'h0001;
  localparam logic [15:0] OPC_UNL_LO = 16'h0010;
  localparam logic [15:0] OPC_UNL_HI = 16'h0011;
  localparam logic [15:0] OPC_LOCK = 16'h0021;
  localparam logic [15:0] OPC_LOCKT = 16'h0031;
  localparam logic [15:0] OPC_AR_SP = 16'h0041;
  localparam logic [15:0] OPC_AR_DEF = 16'h0042;
  localparam logic [15:0] OPC_AR_BOTH = 16'h0043;
  localparam logic [15:0] OPC_RMW_LD = 16'h0060;
  localparam logic [15:0] OPC_RMW_DST = 16'h0061;
  localparam logic [15:0] OPC_RMW_WR = 16'h0062;
  localparam logic [15:0] OPC_CPY_SRC = 16'h1000;
  localparam logic [7:0] OPH_COPY = 8'h11;
  localparam logic [7:0] OPH_PIPE_RD = 8'h20;
  localparam logic [7:0] OPH_PIPE_WR = 8'h21;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ERASE = 4'h1, OP_UNLOCK = 4'h2, OP_LOCK = 4'h3,
    OP_LOCK_TIGHT = 4'h4, OP_RMW_LOAD = 4'h5, OP_RMW_DEST = 4'h6,
    OP_RMW_WRITE = 4'h7, OP_COPY = 4'h8, OP_PIPE_RD = 4'h9,
    OP_PIPE_WR = 4'hA, OP_PAGE_LOAD = 4'hB, OP_PAGE_PROG = 4'hC
  } nic_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_DATA = 2'b01, ST_OP = 2'b10, ST_RESP = 2'b11
  } nic_state_t;

  // request to the flash sequencer
  typedef struct packed {
    nic_op_t code;
    logic [23:0] row;
    logic [23:0] row2;
    logic [7:0] count;
  } nic_op_req_t;
endpackage

// *** tb.sv ***
// Purpose: self-checking bench for the indexed command decoder
// Assumes: short page (32 main, 4 spare words) keeps the run brief
// Notes: expected data comes from the bench's own queue of written words
`timescale 1ns/1ps
module tb;
  import nic_pkg::*;
  localparam logic [15:0] MAIN_B = 16'h0080;
  localparam logic [15:0] SPARE_B = 16'h0010;
  localparam int WORDS = 32;
  localparam int LIMIT = 36;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic slow = 1'b0;
  logic [15:0] i_address = 16'h0000;
  logic [31:0] i_writedata = 32'h0000_0000;
  logic [3:0] i_byteenable = 4'hF;
  logic [31:0] o_readdata, o_dat_wdata, i_dat_rdata, rd, d;
  logic o_waitrequest, o_op_start, i_op_done, o_dat_req, o_dat_we, i_dat_ack, o_unsup_cmd;
  logic [15:0] o_dat_addr;
  logic [1:0] o_area;
  nic_op_req_t o_op;
  nic_op_req_t op_q[$];
  logic [31:0] wq[$];
  int fails = 0;
  int checks = 0;
  int unsup_n = 0;
  int u;
  integer seed = 95;

  nic_decoder #(.ADDR_W(16), .PAGE_BITS(4'h6), .MAIN_BYTES(MAIN_B), .SPARE_BYTES(SPARE_B)) uut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_op(o_op),
    .o_op_start(o_op_start), .i_op_done(i_op_done), .o_dat_req(o_dat_req),
    .o_dat_we(o_dat_we), .o_dat_addr(o_dat_addr), .o_dat_wdata(o_dat_wdata),
    .i_dat_ack(i_dat_ack), .i_dat_rdata(i_dat_rdata), .o_area(o_area),
    .o_unsup_cmd(o_unsup_cmd));
  nic_flash_model flash (
    .i_clock(i_clock), .i_slow(slow), .i_op(o_op), .i_op_start(o_op_start),
    .o_op_done(i_op_done), .i_dat_req(o_dat_req), .i_dat_we(o_dat_we),
    .i_dat_addr(o_dat_addr), .i_dat_wdata(o_dat_wdata), .o_dat_ack(i_dat_ack),
    .o_dat_rdata(i_dat_rdata));

  initial begin
    forever #12.5 i_clock = ~i_clock;
  end
  // record op starts and unsupported pulses as they are sampled
  always @(posedge i_clock) begin
    if (o_op_start === 1'b1) op_q.push_back(o_op);
    if (o_unsup_cmd === 1'b1) unsup_n++;
  end

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one Avalon access; request held until waitrequest is sampled low
  task automatic av(input bit wr, input logic [15:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clock);
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= wd;
    i_byteenable <= 4'($random(seed));
    slow <= 1'($random(seed));
    do begin
      @(posedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 500);
    if (n >= 500) begin
      fails++;
      $display("BAD %0t bus hang", $time);
    end
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  task automatic cmp_op(input nic_op_t code, input logic [23:0] row, input logic [23:0] r2,
                        input logic [7:0] cnt);
    nic_op_req_t g;
    bit ok;
    checks++;
    g = op_q.size() ? op_q.pop_front() : '0;
    ok = (g.code === code);
    if (!(code inside {OP_LOCK, OP_LOCK_TIGHT, OP_RMW_WRITE})) ok &= (g.row === row);
    if (code inside {OP_UNLOCK, OP_COPY}) ok &= (g.row2 === r2);
    if (code inside {OP_COPY, OP_PIPE_RD, OP_PIPE_WR}) ok &= (g.count === cnt);
    if (!ok) begin
      fails++;
      $display("BAD %0t op got %h exp code %h", $time, g, code);
    end
  endtask
  // control command then opcode word with random upper half
  task automatic ctl(input logic [23:0] row, input logic [15:0] opc, input nic_op_t code,
                     input logic [23:0] erow, input logic [23:0] r2, input logic [7:0] cnt,
                     input int du);
    u = unsup_n;
    av(1, CMD_OFF[15:0], {8'h08, row});
    av(1, DATA_OFF[15:0], {16'($random(seed)), opc});
    repeat (2) @(posedge i_clock);
    if (code == OP_NONE) cmp(32'(op_q.size()), 32'h0000_0000, "no op");
    else cmp_op(code, erow, r2, cnt);
    cmp(32'(unsup_n - u), 32'(du), "unsup count");
  endtask

  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    av(0, CFG_OFF[15:0], 0);
    cmp(rd, 32'h0000_0060, "cfg reset");
    av(0, GEOM_OFF[15:0], 0);
    cmp(rd, {SPARE_B, MAIN_B}, "geom reset");
    cmp(32'(o_area), 32'h0000_0002, "area reset");
    av(0, DATA_OFF[15:0], 0);
    cmp(rd, 32'h0000_0000, "no command read");
    // full main-area write, then rewrite command and read it back
    av(1, CMD_OFF[15:0], 32'h0400_0081);
    for (int k = 0; k < WORDS; k++) begin
      wq.push_back($random(seed));
      av(1, 16'(DATA_OFF + 4 * k), wq[k]);
    end
    cmp_op(OP_PAGE_PROG, 24'h00_0081, 0, 0);
    av(1, CMD_OFF[15:0], 32'h0400_0081);
    for (int k = 0; k < WORDS; k++) begin
      av(0, 16'(DATA_OFF + 4 * k), 0);
      cmp(rd, wq[k], "xfer read");
    end
    cmp_op(OP_PAGE_LOAD, 24'h00_0081, 0, 0);
    // buffer path from word 2, up to and past the page end
    av(1, CMD_OFF[15:0], 32'h0000_0008);
    av(0, DATA_OFF[15:0], 0);
    cmp(rd, wq[2], "buf read");
    d = $random(seed);
    av(1, 16'(DATA_OFF + 4 * (LIMIT - 3)), d);
    av(0, 16'(DATA_OFF + 4 * (LIMIT - 3)), 0);
    cmp(rd, d, "buf last word");
    av(0, 16'(DATA_OFF + 4 * (LIMIT - 2)), 0);
    cmp(rd, 32'h0000_0000, "buf past page");
    // control operations
    ctl(24'h00_00C5, 16'h0001, OP_ERASE, 24'h00_00C0, 0, 0, 0);
    ctl(24'h00_0040, 16'h0010, OP_NONE, 0, 0, 0, 0);
    ctl(24'h00_0100, 16'h0011, OP_UNLOCK, 24'h00_0100, 24'h00_0040, 0, 0);
    ctl(24'h00_0000, 16'h0021, OP_LOCK, 0, 0, 0, 0);
    ctl(24'h00_0000, 16'h0031, OP_LOCK_TIGHT, 0, 0, 0, 0);
    ctl(24'h00_0085, 16'h0060, OP_RMW_LOAD, 24'h00_0085, 0, 0, 0);
    ctl(24'h00_0086, 16'h0061, OP_RMW_DEST, 24'h00_0086, 0, 0, 0);
    ctl(24'h00_0086, 16'h0062, OP_RMW_WRITE, 0, 0, 0, 0);
    ctl(24'h00_0080, 16'h1000, OP_NONE, 0, 0, 0, 0);
    ctl(24'h00_0200, 16'h1103, OP_COPY, 24'h00_0200, 24'h00_0080, 8'h03, 0);
    ctl(24'h00_0040, 16'h2004, OP_PIPE_RD, 24'h00_0040, 0, 8'h04, 0);
    ctl(24'h00_0040, 16'h2102, OP_PIPE_WR, 24'h00_0040, 0, 8'h02, 0);
    ctl(24'h00_007E, 16'h2004, OP_NONE, 0, 0, 0, 1);
    ctl(24'h00_0000, 16'h0077, OP_NONE, 0, 0, 0, 1);
    for (int a = 1; a < 4; a++) begin
      ctl(0, 16'(16'h0040 + ((a * 2) % 3 + 1)), OP_NONE, 0, 0, 0, 0);
      cmp(32'(o_area), 32'((a * 2) % 3 + 1), "area");
    end
    // five page bits move the split point
    av(1, CFG_OFF[15:0], 32'h0000_0050);
    ctl(24'h00_0035, 16'h0001, OP_ERASE, 24'h00_0020, 0, 0, 0);
    // refused command words
    av(1, CFG_OFF[15:0], 32'h0000_0061);
    u = unsup_n;
    av(1, CMD_OFF[15:0], 32'h0400_0081);
    av(1, CMD_OFF[15:0], 32'h0000_0008);
    av(1, CFG_OFF[15:0], 32'h0000_0060);
    av(1, CMD_OFF[15:0], 32'h2400_0081);
    av(1, CMD_OFF[15:0], 32'h0A00_0000);
    repeat (2) @(posedge i_clock);
    cmp(32'(unsup_n - u), 32'h0000_0004, "refused commands");
    cmp(32'(op_q.size()), 32'h0000_0000, "no stray op");
    // reset in mid-run must restore area, config and command state
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    cmp(32'(o_area), 32'h0000_0002, "area after reset");
    av(0, STAT_OFF[15:0], 0);
    cmp(rd, 32'h0000_0040, "status after reset");
    av(0, DATA_OFF[15:0], 0);
    cmp(rd, 32'h0000_0000, "no command after reset");
    finish_test();
  end
endmodule
